// file: ext_bus_map.svh
// Register offsets, field positions, reset values and timing counts of the bus-assist block
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define BUFFER_ENABLE_CONFIG_OFS 12'h18c
`define ACK_GENERATION_CONFIG_OFS 12'h190
`define ASSIST_STATUS_OFS 12'h194

// ****************************************************************
// Buffer enable configuration fields
// ****************************************************************
`define BOOT_PREDRIVE_LSB 0
`define BOOT_POSTDRIVE_LSB 3
`define AUX_PREDRIVE_LSB 5
`define AUX_POSTDRIVE_LSB 8
`define DISK_PREDRIVE_LSB 10
`define DISK_POSTDRIVE_LSB 13
`define BOOT_BUF_ON_AUX_BIT 16
`define BOOT_BUF_ON_DISK_BIT 17
`define BOOT_BUF_ON_CARD_BIT 18
`define PERIPH_BUF_ON_AUX_BIT 19
`define PERIPH_BUF_ON_DISK_BIT 20
`define PERIPH_BUF_ON_CARD_BIT 21
`define CARD_PREDRIVE_LSB 22
`define CARD_POSTDRIVE_LSB 25
`define DISK_READ_ON_WRITE_BIT 27
`define CARD_READ_ON_WRITE_BIT 28
`define BUFFER_ENABLE_CONFIG_MASK 32'h1fffffff
`define PREDRIVE_MAX_CODE 3'h5

// ****************************************************************
// Acknowledge generation configuration fields
// ****************************************************************
`define CARD_WAIT_COUNT_LSB 0
`define DISK_WAIT_COUNT_LSB 8
`define CARD_ACK_GEN_EN_BIT 16
`define CARD_READY_EN_BIT 17
`define DISK_ACK_GEN_EN_BIT 18
`define DISK_READY_EN_BIT 19
`define ACK_GENERATION_CONFIG_MASK 32'h000fffff

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define CONFIG_RESET 32'h00000000
`define ACK_BASE_CLOCKS 9'h001
`endif

// file: ext_bus_pkg.sv
// Types shared by the bus-assist block
package ext_bus_pkg;

  // Progress of one acknowledge generator
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_COUNT = 2'b01,
    ACK_STRETCH = 2'b10,
    ACK_RELEASE = 2'b11
  } ack_phase_t;

  // Whole state of the block, one flop bank
  typedef struct packed {
    logic [31:0] buf_cfg;
    logic [31:0] ack_cfg;
    logic [31:0] rdata;
    logic [3:0] sel_n;
    logic [3:0][2:0] pre_cnt;
    logic [3:0][1:0] post_cnt;
    logic boot_buf_n;
    logic periph_buf_n;
    logic disk_rd_n;
    logic disk_wr_n;
    logic card_rd_n;
    logic card_wr_n;
    logic ack_n;
    logic [1:0] done;
    ack_phase_t [1:0] phase;
    logic [1:0][8:0] wait_cnt;
  } state_t;

endpackage

// file: ext_bus_assist.sv
// Buffer enables, strobe gating and transfer acknowledge for the external bus
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`include "ext_bus_map.svh"

// What this block does
// - Boot buffer on boot select; peripheral buffer never
// - Other selects enable buffers per config bit
// - Buffer leads select by predrive, trails by postdrive
// - Predrive delays the select pin's falling edge
// - Internal termination shortens visible select by predrive
// - One timing per select, shared by both buffers
// - Three-bit predrive fields, zero to five clocks
// - Two-bit postdrive fields, zero to three clocks
// - Bit 27 adds disk read strobe on writes
// - Bit 28 adds card read strobe on writes
// - Strobes are selects gated with read/write line
// - Acknowledge generated only when enable bit set
// - Ready input stretches only when its bit set
// - Eight-bit wait count for disk and card selects
// - Acknowledge wait count plus two clocks after strobe
// - Acknowledge two clocks after ready returns high
// - Disk and card generators behave identically
// - Buffer enables are active low
// - Disk strobes are active low

module ext_bus_assist #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic [3:0] SELECT_REQ_I,
  input wire logic BUS_READ_NOT_WRITE_I,
  input wire logic READY_I,
  output logic BOOT_SELECT_N_O,
  output logic AUX_SELECT_N_O,
  output logic DISK_SELECT_N_O,
  output logic CARD_SELECT_N_O,
  output logic BOOT_BUFFER_ENABLE_N_O,
  output logic PERIPH_BUFFER_ENABLE_N_O,
  output logic DISK_READ_STROBE_N_O,
  output logic DISK_WRITE_STROBE_N_O,
  output logic CARD_READ_STROBE_N_O,
  output logic CARD_WRITE_STROBE_N_O,
  output logic TRANSFER_ACK_N_O
);

  // ****************************************************************
  // Constants
  // ****************************************************************

  // Select index of each chip select
  localparam int BOOT = 0;
  localparam int AUX = 1;
  localparam int DISK = 2;
  localparam int CARD = 3;

  // Field positions per select, indexed by select number
  localparam int PRE_LSB [4] = '{`BOOT_PREDRIVE_LSB, `AUX_PREDRIVE_LSB,
                                `DISK_PREDRIVE_LSB, `CARD_PREDRIVE_LSB};
  localparam int POST_LSB [4] = '{`BOOT_POSTDRIVE_LSB, `AUX_POSTDRIVE_LSB,
                                 `DISK_POSTDRIVE_LSB, `CARD_POSTDRIVE_LSB};

  // Generator 0 serves the disk select, generator 1 the card select
  localparam int GEN_SEL [2] = '{DISK, CARD};
  localparam int GEN_WAIT_LSB [2] = '{`DISK_WAIT_COUNT_LSB, `CARD_WAIT_COUNT_LSB};
  localparam int GEN_EN_BIT [2] = '{`DISK_ACK_GEN_EN_BIT, `CARD_ACK_GEN_EN_BIT};
  localparam int GEN_RDY_BIT [2] = '{`DISK_READY_EN_BIT, `CARD_READY_EN_BIT};

  // ****************************************************************
  // State
  // ****************************************************************

  ext_bus_pkg::state_t st_ff; // Every flop of the block
  ext_bus_pkg::state_t nxt_st; // Next value of every flop

  // Helpers of the combinational process
  logic [3:0] hold; // Select wants its buffers this cycle
  logic [2:0] pre_code; // Predrive code of the select at hand
  logic [1:0] post_code; // Postdrive code of the select at hand
  logic [8:0] target; // Count at which the acknowledge fires
  logic [1:0] fire; // Generator raises acknowledge next edge
  logic act; // Select pin currently driven low
  logic gen_en; // Generator enabled
  logic rdy_en; // Ready input honoured

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // All behaviour lives here; the flop bank below only registers it
  always_comb begin
    nxt_st = st_ff;
    hold = '0;
    pre_code = '0;
    post_code = '0;
    target = '0;
    fire = '0;
    act = 1'b0;
    gen_en = 1'b0;
    rdy_en = 1'b0;

    // Read data stand for one cycle only, zero otherwise
    nxt_st.rdata = '0;

    // Register writes; reserved bits are kept at zero
    if (WR_I) begin
      unique case (ADDR_I)
        `BUFFER_ENABLE_CONFIG_OFS: begin
          nxt_st.buf_cfg = WDATA_I & `BUFFER_ENABLE_CONFIG_MASK;
        end
        `ACK_GENERATION_CONFIG_OFS: begin
          nxt_st.ack_cfg = WDATA_I & `ACK_GENERATION_CONFIG_MASK;
        end
        default: begin
          // Unmapped or read-only: write ignored
        end
      endcase
    end

    // Register reads, answered in the following cycle
    if (RD_I) begin
      unique case (ADDR_I)
        `BUFFER_ENABLE_CONFIG_OFS: begin
          nxt_st.rdata = st_ff.buf_cfg;
        end
        `ACK_GENERATION_CONFIG_OFS: begin
          nxt_st.rdata = st_ff.ack_cfg;
        end
        `ASSIST_STATUS_OFS: begin
          // Live view of pins and generator progress
          nxt_st.rdata = {22'h000000, st_ff.phase[1], st_ff.phase[0],
                          ~st_ff.periph_buf_n, ~st_ff.boot_buf_n, ~st_ff.sel_n};
        end
        default: begin
          // Unmapped address reads as zero
          nxt_st.rdata = '0;
        end
      endcase
    end

    // Per-select predrive and postdrive sequencing
    for (int s = 0; s < 4; s++) begin
      // Each select owns its timing fields
      pre_code = st_ff.buf_cfg[PRE_LSB[s] +: 3];
      post_code = st_ff.buf_cfg[POST_LSB[s] +: 2];
      // Codes above five are undefined; treat as five
      if (pre_code > `PREDRIVE_MAX_CODE) begin
        pre_code = `PREDRIVE_MAX_CODE;
      end
      act = ~st_ff.sel_n[s];
      if (!SELECT_REQ_I[s]) begin
        // Request gone: release the pin, rearm predrive
        nxt_st.sel_n[s] = 1'b1;
        nxt_st.pre_cnt[s] = '0;
      end else if (act || (st_ff.pre_cnt[s] >= pre_code)) begin
        // Falling edge held off by predrive clocks
        nxt_st.sel_n[s] = 1'b0;
      end else begin
        // Still in predrive; the pin stays high. Because the
        // request length is fixed elsewhere, the visible select
        // comes out shorter by the predrive
        nxt_st.pre_cnt[s] = st_ff.pre_cnt[s] + 3'h1;
      end
      // Postdrive loads on the pin's rising edge
      if (act && nxt_st.sel_n[s]) begin
        nxt_st.post_cnt[s] = post_code;
      end else if (st_ff.post_cnt[s] != 2'h0) begin
        nxt_st.post_cnt[s] = st_ff.post_cnt[s] - 2'h1;
      end
      // Buffers run from request start to end of postdrive
      hold[s] = SELECT_REQ_I[s] | (nxt_st.post_cnt[s] != 2'h0);
    end

    // Boot buffer: always on boot select, optional elsewhere
    // Optional terms use the per-select enable bits
    // Outputs are active low
    nxt_st.boot_buf_n = ~(hold[BOOT]
                         | (hold[AUX] & st_ff.buf_cfg[`BOOT_BUF_ON_AUX_BIT])
                         | (hold[DISK] & st_ff.buf_cfg[`BOOT_BUF_ON_DISK_BIT])
                         | (hold[CARD] & st_ff.buf_cfg[`BOOT_BUF_ON_CARD_BIT]));

    // Peripheral buffer: never on boot select
    // Optional terms use the per-select enable bits
    nxt_st.periph_buf_n = ~((hold[AUX] & st_ff.buf_cfg[`PERIPH_BUF_ON_AUX_BIT])
                           | (hold[DISK] & st_ff.buf_cfg[`PERIPH_BUF_ON_DISK_BIT])
                           | (hold[CARD] & st_ff.buf_cfg[`PERIPH_BUF_ON_CARD_BIT]));

    // Disk strobes: select pin gated with read/write
    // Both strobes are active low
    // Read strobe optionally also on writes
    nxt_st.disk_rd_n = nxt_st.sel_n[DISK]
                       | ~(BUS_READ_NOT_WRITE_I | st_ff.buf_cfg[`DISK_READ_ON_WRITE_BIT]);
    nxt_st.disk_wr_n = nxt_st.sel_n[DISK] | BUS_READ_NOT_WRITE_I;

    // Card strobes, same gating from the card select
    // Read strobe optionally also on writes
    nxt_st.card_rd_n = nxt_st.sel_n[CARD]
                       | ~(BUS_READ_NOT_WRITE_I | st_ff.buf_cfg[`CARD_READ_ON_WRITE_BIT]);
    nxt_st.card_wr_n = nxt_st.sel_n[CARD] | BUS_READ_NOT_WRITE_I;

    // Acknowledge generators, one each for disk and card select, identical
    for (int g = 0; g < 2; g++) begin
      act = ~st_ff.sel_n[GEN_SEL[g]];
      gen_en = st_ff.ack_cfg[GEN_EN_BIT[g]];
      rdy_en = st_ff.ack_cfg[GEN_RDY_BIT[g]];
      // Wait count from its own byte
      target = {1'b0, st_ff.ack_cfg[GEN_WAIT_LSB[g] +: 8]} + `ACK_BASE_CLOCKS;
      if (!act) begin
        // Strobe gone: cycle over, whatever stage was reached
        nxt_st.phase[g] = ext_bus_pkg::ACK_IDLE;
        nxt_st.done[g] = 1'b0;
        nxt_st.wait_cnt[g] = '0;
      end else begin
        unique case (st_ff.phase[g])
          ext_bus_pkg::ACK_IDLE: begin
            // Start once per strobe, only if enabled
            // A disabled generator stays idle
            if (gen_en && !st_ff.done[g]) begin
              nxt_st.phase[g] = ext_bus_pkg::ACK_COUNT;
              nxt_st.wait_cnt[g] = 9'h001;
            end
          end
          ext_bus_pkg::ACK_COUNT: begin
            if (rdy_en && !READY_I) begin
              // Device holds ready low: stretch
              // Relies on ready falling before the count ends
              nxt_st.phase[g] = ext_bus_pkg::ACK_STRETCH;
            end else if (st_ff.wait_cnt[g] == target) begin
              // Wait count plus two clocks after strobe
              fire[g] = 1'b1;
              nxt_st.phase[g] = ext_bus_pkg::ACK_IDLE;
              nxt_st.done[g] = 1'b1;
            end else begin
              nxt_st.wait_cnt[g] = st_ff.wait_cnt[g] + 9'h001;
            end
          end
          ext_bus_pkg::ACK_STRETCH: begin
            // Hold while ready is low
            if (READY_I) begin
              nxt_st.phase[g] = ext_bus_pkg::ACK_RELEASE;
            end
          end
          ext_bus_pkg::ACK_RELEASE: begin
            // Acknowledge two clocks after ready seen high
            fire[g] = 1'b1;
            nxt_st.phase[g] = ext_bus_pkg::ACK_IDLE;
            nxt_st.done[g] = 1'b1;
          end
        endcase
      end
    end

    // One acknowledge pin shared; the selects never overlap
    nxt_st.ack_n = ~(fire[0] | fire[1]);
  end

  // ****************************************************************
  // Flop bank
  // ****************************************************************

  // Synchronous reset; active-low outputs come up inactive
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_ff <= '0;
      st_ff.buf_cfg <= `CONFIG_RESET;
      st_ff.ack_cfg <= `CONFIG_RESET;
      st_ff.sel_n <= 4'hf;
      st_ff.boot_buf_n <= 1'b1;
      st_ff.periph_buf_n <= 1'b1;
      st_ff.disk_rd_n <= 1'b1;
      st_ff.disk_wr_n <= 1'b1;
      st_ff.card_rd_n <= 1'b1;
      st_ff.card_wr_n <= 1'b1;
      st_ff.ack_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs, each straight from its flop
  // ****************************************************************

  // Register read data
  assign RDATA_O = st_ff.rdata;

  // Select pins after predrive delay
  assign BOOT_SELECT_N_O = st_ff.sel_n[BOOT];
  assign AUX_SELECT_N_O = st_ff.sel_n[AUX];
  assign DISK_SELECT_N_O = st_ff.sel_n[DISK];
  assign CARD_SELECT_N_O = st_ff.sel_n[CARD];

  // Buffer enables
  assign BOOT_BUFFER_ENABLE_N_O = st_ff.boot_buf_n;
  assign PERIPH_BUFFER_ENABLE_N_O = st_ff.periph_buf_n;

  // Read and write strobes
  assign DISK_READ_STROBE_N_O = st_ff.disk_rd_n;
  assign DISK_WRITE_STROBE_N_O = st_ff.disk_wr_n;
  assign CARD_READ_STROBE_N_O = st_ff.card_rd_n;
  assign CARD_WRITE_STROBE_N_O = st_ff.card_wr_n;

  // Transfer acknowledge, one-cycle low pulse
  assign TRANSFER_ACK_N_O = st_ff.ack_n;

endmodule

// file: ext_bus_assist_chk.sv
// Checker for buffer, strobe and acknowledge timing at the bus-assist pins
`timescale 1ns/1ns
`include "ext_bus_map.svh"
module ext_bus_assist_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic [3:0] SELECT_REQ_I,
  input wire logic BUS_READ_NOT_WRITE_I,
  input wire logic READY_I,
  input wire logic BOOT_SELECT_N_O,
  input wire logic AUX_SELECT_N_O,
  input wire logic DISK_SELECT_N_O,
  input wire logic CARD_SELECT_N_O,
  input wire logic BOOT_BUFFER_ENABLE_N_O,
  input wire logic PERIPH_BUFFER_ENABLE_N_O,
  input wire logic DISK_READ_STROBE_N_O,
  input wire logic DISK_WRITE_STROBE_N_O,
  input wire logic CARD_READ_STROBE_N_O,
  input wire logic CARD_WRITE_STROBE_N_O,
  input wire logic TRANSFER_ACK_N_O
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [31:0] bcfg_ff, acfg_ff; // Shadow copies, built from observed writes
  logic [3:0] req_q_ff, pin_q_ff; // Previous request and pin levels
  logic [8:0] lead_ff, acnt_ff; // Clocks since request rose, since select fell
  logic [2:0] hold_ff; // Clocks a buffer stayed on after selects rose
  logic [1:0] last_q_ff; // Post code of the last active select
  logic acked_ff; // Acknowledge already seen in this select assertion
  wire [3:0] pin = ~{CARD_SELECT_N_O, DISK_SELECT_N_O, AUX_SELECT_N_O, BOOT_SELECT_N_O};
  wire rdy_on = (pin[2] && acfg_ff[19] && acfg_ff[18]) || (pin[3] && acfg_ff[17] && acfg_ff[16]);
  // Pre code of the active select; codes above five act as five
  function automatic logic [2:0] pre_of(input logic [3:0] p, input logic [31:0] c);
    logic [2:0] v;
    v = p[0] ? c[2:0] : p[1] ? c[7:5] : p[2] ? c[12:10] : c[24:22];
    return (v > 3'h5) ? 3'h5 : v;
  endfunction
  function automatic logic [1:0] post_of(input logic [3:0] p, input logic [31:0] c);
    return p[0] ? c[4:3] : p[1] ? c[9:8] : p[2] ? c[14:13] : c[26:25];
  endfunction
  // Counters saturate so a long idle never wraps into a false match
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      bcfg_ff <= 32'h0;
      acfg_ff <= 32'h0;
      req_q_ff <= 4'h0;
      pin_q_ff <= 4'h0;
      lead_ff <= 9'h0;
      acnt_ff <= 9'h0;
      hold_ff <= 3'h0;
      last_q_ff <= 2'h0;
      acked_ff <= 1'b0;
    end else begin
      if (WR_I && ADDR_I == `BUFFER_ENABLE_CONFIG_OFS) bcfg_ff <= WDATA_I & 32'h1fffffff;
      if (WR_I && ADDR_I == `ACK_GENERATION_CONFIG_OFS) acfg_ff <= WDATA_I & 32'h000fffff;
      req_q_ff <= SELECT_REQ_I;
      pin_q_ff <= pin;
      lead_ff <= (|(SELECT_REQ_I & ~req_q_ff)) ? 9'h1 : lead_ff + {8'h0, ~&lead_ff};
      acnt_ff <= (|(pin & ~pin_q_ff)) ? 9'h1 : acnt_ff + {8'h0, ~&acnt_ff};
      hold_ff <= (pin == 4'h0 && !(BOOT_BUFFER_ENABLE_N_O && PERIPH_BUFFER_ENABLE_N_O)) ?
        hold_ff + {2'h0, ~&hold_ff} : 3'h0;
      if (|pin) last_q_ff <= post_of(pin, bcfg_ff);
      acked_ff <= (pin == 4'h0) ? 1'b0 : (acked_ff || !TRANSFER_ACK_N_O);
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_ready_back;
    !READY_I ##1 READY_I;
  endsequence
  sequence s_ack_two;
    TRANSFER_ACK_N_O ##1 !TRANSFER_ACK_N_O;
  endsequence
  a_buf_select: assert property ((|pin) |-> BOOT_BUFFER_ENABLE_N_O == !(pin[0]
    | pin[1] & bcfg_ff[16] | pin[2] & bcfg_ff[17] | pin[3] & bcfg_ff[18]) && PERIPH_BUFFER_ENABLE_N_O
    == !(pin[1] & bcfg_ff[19] | pin[2] & bcfg_ff[20] | pin[3] & bcfg_ff[21])) else $error("buffer enable level off");
  a_pre_lead: assert property ((|(pin & ~pin_q_ff)) |-> lead_ff == pre_of(pin, bcfg_ff) + 1)
    else $error("select fall not delayed by pre-drive");
  a_post_trail: assert property ($rose(BOOT_BUFFER_ENABLE_N_O) || $rose(PERIPH_BUFFER_ENABLE_N_O) |->
    hold_ff == last_q_ff) else $error("buffer release not post-drive after select");
  a_disk_strobes: assert property ($stable(BUS_READ_NOT_WRITE_I) |->
    DISK_WRITE_STROBE_N_O == (DISK_SELECT_N_O | BUS_READ_NOT_WRITE_I) && DISK_READ_STROBE_N_O ==
    (DISK_SELECT_N_O | !(BUS_READ_NOT_WRITE_I | bcfg_ff[27]))) else $error("disk strobes wrong");
  a_card_strobes: assert property ($stable(BUS_READ_NOT_WRITE_I) |->
    CARD_WRITE_STROBE_N_O == (CARD_SELECT_N_O | BUS_READ_NOT_WRITE_I) && CARD_READ_STROBE_N_O ==
    (CARD_SELECT_N_O | !(BUS_READ_NOT_WRITE_I | bcfg_ff[28]))) else $error("card strobes wrong");
  a_disk_wait: assert property ($fell(TRANSFER_ACK_N_O) && pin[2] && !acfg_ff[19] |->
    acnt_ff == acfg_ff[15:8] + 2) else $error("disk acknowledge delay wrong");
  a_card_wait: assert property ($fell(TRANSFER_ACK_N_O) && pin[3] && !acfg_ff[17] |->
    acnt_ff == acfg_ff[7:0] + 2) else $error("card acknowledge delay wrong");
  a_ready_stretch: assert property ((rdy_on && !acked_ff) ##0 s_ready_back |=> s_ack_two)
    else $error("acknowledge not two clocks after ready");
  a_ack_enable: assert property (!TRANSFER_ACK_N_O |-> (pin[2] && acfg_ff[18]) ||
    (pin[3] && acfg_ff[16])) else $error("acknowledge while generation off");
  a_ack_single: assert property (!TRANSFER_ACK_N_O |-> !acked_ff ##1 TRANSFER_ACK_N_O)
    else $error("acknowledge longer than one pulse");
endmodule

bind ext_bus_assist ext_bus_assist_chk #(.ADDR_W(ADDR_W)) chk_u (.CLK_I, .SRST_I, .ADDR_I,
  .WDATA_I, .WR_I, .SELECT_REQ_I, .BUS_READ_NOT_WRITE_I, .READY_I, .BOOT_SELECT_N_O,
  .AUX_SELECT_N_O, .DISK_SELECT_N_O, .CARD_SELECT_N_O, .BOOT_BUFFER_ENABLE_N_O,
  .PERIPH_BUFFER_ENABLE_N_O, .DISK_READ_STROBE_N_O, .DISK_WRITE_STROBE_N_O,
  .CARD_READ_STROBE_N_O, .CARD_WRITE_STROBE_N_O, .TRANSFER_ACK_N_O);

// file: ext_bus_partner.sv
// Attached drive or card model that holds ready low to stretch accesses
`timescale 1ns/1ns
module ext_bus_partner (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] strobe_n_i,
  input wire logic [7:0] stall_i,
  output logic ready_o
);
  logic [7:0] cnt_ff; // Clocks of stall left
  logic low_q_ff; // Some strobe was low last clock
  wire low = ~&strobe_n_i;
  // Stall starts one clock after a strobe falls, well inside the pull-low limit
  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= 8'h00;
      low_q_ff <= 1'b0;
    end else begin
      low_q_ff <= low;
      if (low && !low_q_ff) cnt_ff <= stall_i;
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
  end
  // Line has a pull-up, so it reads high whenever the model is not stalling
  assign ready_o = (cnt_ff == 8'h00);
endmodule

// file: tb_top.sv
// Self-checking bench for the bus-assist block
`timescale 1ns/1ns
`include "ext_bus_map.svh"
module tb_top;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rw = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] req = 4'h0;
  logic [7:0] stall = 8'h00;
  wire ready, boot_buf_n, periph_buf_n, ack_n;
  wire [31:0] rdata;
  wire [3:0] sel_n, stb_n; // Strobes: card write, card read, disk write, disk read
  int n_mismatch = 0;
  int compares = 0;
  ext_bus_assist dut_u (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .SELECT_REQ_I(req), .BUS_READ_NOT_WRITE_I(rw), .READY_I(ready),
    .BOOT_SELECT_N_O(sel_n[0]), .AUX_SELECT_N_O(sel_n[1]), .DISK_SELECT_N_O(sel_n[2]),
    .CARD_SELECT_N_O(sel_n[3]), .BOOT_BUFFER_ENABLE_N_O(boot_buf_n),
    .PERIPH_BUFFER_ENABLE_N_O(periph_buf_n), .DISK_READ_STROBE_N_O(stb_n[0]),
    .DISK_WRITE_STROBE_N_O(stb_n[1]), .CARD_READ_STROBE_N_O(stb_n[2]),
    .CARD_WRITE_STROBE_N_O(stb_n[3]), .TRANSFER_ACK_N_O(ack_n));
  ext_bus_partner partner_u (.clk_i(clk), .srst_i(srst), .strobe_n_i(stb_n), .stall_i(stall),
    .ready_o(ready));
  initial forever #50 clk = ~clk;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One select access: clocks to select fall, clocks to acknowledge (40 = none)
  task automatic acc(input int s, input logic dir, output int lead, output int k,
    output logic [5:0] v);
    @(posedge clk);
    req <= 4'h1 << s; rw <= dir;
    lead = 0;
    do begin @(posedge clk); #1 lead++; end while (sel_n[s] === 1'b1 && lead < 20);
    v = {boot_buf_n, periph_buf_n, stb_n};
    k = 0;
    while (ack_n === 1'b1 && k < 40) begin @(posedge clk); #1 k++; end
    @(posedge clk);
    req <= 4'h0;
    repeat (6) @(posedge clk);
    #1 chk("buffers released", {boot_buf_n, periph_buf_n}, 2'b11);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_regs;
    logic [31:0] d;
    rd_reg(`BUFFER_ENABLE_CONFIG_OFS, d);
    chk("buffer cfg reset", d, 32'h0);
    wr_reg(`BUFFER_ENABLE_CONFIG_OFS, 32'hffffffff);
    wr_reg(`ACK_GENERATION_CONFIG_OFS, 32'hffffffff);
    wr_reg(12'h004, 32'h0);
    rd_reg(`BUFFER_ENABLE_CONFIG_OFS, d);
    chk("buffer cfg fields", d, 32'h1fffffff);
    rd_reg(`ACK_GENERATION_CONFIG_OFS, d);
    chk("ack cfg fields", d, 32'h000fffff);
    rd_reg(12'h000, d);
    chk("unmapped read", d, 32'h0);
    rd_reg(`ASSIST_STATUS_OFS, d);
    chk("idle status", d, 32'h0);
    rd_reg(`ACK_GENERATION_CONFIG_OFS, d);
    @(posedge clk);
    #1 chk("read data one cycle", rdata, 32'h0);
  endtask
  task automatic sc_buffers;
    int lead, k;
    logic [5:0] v;
    wr_reg(`BUFFER_ENABLE_CONFIG_OFS, 32'h0038001f); // Boot pre code 7, post 3; periph on others
    wr_reg(`ACK_GENERATION_CONFIG_OFS, 32'h0);
    acc(0, 1'b1, lead, k, v);
    chk("boot lead", lead, 6);
    chk("boot buffers", v[5:4], 2'b01);
    chk("boot no ack", k, 40);
    acc(1, 1'b1, lead, k, v);
    chk("aux lead", lead, 1);
    chk("aux buffers", v[5:4], 2'b10);
  endtask
  task automatic sc_disk;
    int lead, k;
    logic [5:0] v;
    for (int i = 0; i < 4; i++) begin
      wr_reg(`BUFFER_ENABLE_CONFIG_OFS, 32'h00102c00 | (i[0] << 27)); // Pre 3, post 1
      wr_reg(`ACK_GENERATION_CONFIG_OFS, 32'h00040300); // Wait 3, no ready
      acc(2, i[1], lead, k, v);
      chk("disk lead", lead, 4);
      chk("disk ack", k, 5);
      chk("disk strobes", v[3:0], {3'b111, !(i[1] | i[0])} & {2'b11, i[1], 1'b1});
      chk("disk buffers", v[5:4], 2'b10);
    end
  endtask
  task automatic sc_card;
    int lead, k;
    logic [5:0] v;
    for (int m = 0; m < 3; m++) begin
      wr_reg(`BUFFER_ENABLE_CONFIG_OFS, 32'h14040000); // Post 2, boot buffer, read on write
      wr_reg(`ACK_GENERATION_CONFIG_OFS, 32'h2 | ((m > 0) << 16) | ((m == 2) << 17));
      stall <= 8'h06;
      acc(3, 1'b0, lead, k, v);
      chk("card lead", lead, 1);
      chk("card ack", k, (m == 0) ? 40 : (m == 1) ? 4 : 9);
      chk("card strobes", v[3:0], 4'b0011);
      chk("card buffers", v[5:4], 2'b01);
    end
  endtask
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    sc_regs();
    sc_buffers();
    sc_disk();
    sc_card();
    stop_test();
  end
  // Whole run needs about three hundred clocks; three thousand means a hang
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule
